// [rtl/dfm_monitor.sv]
`timescale 1ns/10ps

// Function
// - Any detected fault sets its flag
// - Per-flag enable gates interrupt output
// - Enabled fault can force outputs diagnostic
// - Static flags hold until reset; watchdog and buffer static flags also host clearable
// - Temporary flags follow their cause
// - Start-up flags checked only during start-up
// - Temporary supply over-voltage flag
// - Temporary supply under-voltage flag
// - Analog rail under-voltage temporary flag
// - I2C transfer error temporary flag
// - Shadow double-bit error static flag
// - Shadow single-bit error flagged and corrected
// - Start-up memory double-bit error static flag
// - Start-up memory single-bit error corrected, flagged
// - Oscillator frequency outside range flags
// - Stopped transmitter oscillator flags
// - Internal oscillator failure static flag
// - Watchdog expires, flags, restarts cyclically
// - Writing zero halts the watchdog
// - Silicon crack static flag
// - Output mean offset temporary flag
// - Offset error always switches outputs off
// - Eight consecutive failed checks latch outputs off
// - Static buffer failure cleared by host
module dfm_monitor
  import dfm_pkg::*;
#(
  parameter int FREQ_W = DFM_FW,
  parameter int WD_W = DFM_WDW
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Fault detectors
  input dfm_pkg::dfm_fault_t fault_in,
  input wire logic startup_active,
  input dfm_pkg::dfm_nvm_t nvm_in,
  input wire logic [dfm_pkg::DFM_DW-1:0] shd_raw,
  input wire logic [dfm_pkg::DFM_DW-1:0] shd_fix,
  // Transmitter oscillator measurement
  input wire logic [FREQ_W-1:0] txo_freq,
  input wire logic txo_running,
  input wire logic [FREQ_W-1:0] txo_freq_lo,
  input wire logic [FREQ_W-1:0] txo_freq_hi,
  // Host control
  input wire logic [dfm_pkg::DFM_NFLAG-1:0] irq_enable,
  input wire logic [dfm_pkg::DFM_NFLAG-1:0] diag_enable,
  input wire logic wd_load,
  input wire logic [dfm_pkg::DFM_WDW-1:0] wd_value,
  input wire logic obuf_static_clr,
  input wire logic wd_flag_clr,
  // Status and outputs
  output logic [dfm_pkg::DFM_NFLAG-1:0] flags,
  output logic alarm_request_n,
  output dfm_pkg::dfm_out_mode_t out_mode,
  output logic [dfm_pkg::DFM_DW-1:0] nvm_data_out,
  output logic [dfm_pkg::DFM_DW-1:0] shd_data_out
);
  import dfm_pkg::*;

  // Counter must reach the try count
  if (FREQ_W < 1 || WD_W != DFM_WDW || DFM_OBUF_TRIES > (1 << DFM_CHKW)) begin : g_bad_param
    $error("dfm_monitor: unsupported parameter");
  end

  dfm_state_t st_r;
  dfm_state_t st_nxt;
  logic [DFM_NFLAG-1:0] cause;
  logic wd_expire;

  // ---------------------------------------------------------------
  // Causes
  // ---------------------------------------------------------------
  always_comb begin
    cause = '0;
    cause[F_OVERV] = fault_in.ext_over;
    cause[F_UNDERV] = fault_in.ext_under;
    cause[F_ANA_UV] = fault_in.ana_uv;
    cause[F_DATA_ACC] = fault_in.data_acc;
    cause[F_PROTO] = fault_in.proto_err;
    cause[F_SHD_DED] = fault_in.shd_ded;
    cause[F_SHD_SED] = fault_in.shd_sed;
    cause[F_NVM_DED] = nvm_in.valid & nvm_in.ded;
    cause[F_NVM_SED] = nvm_in.valid & nvm_in.sed;
    cause[F_TXO_FREQ] = (txo_freq < txo_freq_lo) | (txo_freq > txo_freq_hi);
    cause[F_TXO_STOP] = ~txo_running;
    cause[F_INT_OSC] = fault_in.int_osc_fail;
    cause[F_BUS] = fault_in.bus_fail;
    cause[F_WDOG] = wd_expire;
    cause[F_CRACK] = fault_in.crack;
    cause[F_OBUF_TMP] = fault_in.obuf_fault;
  end

  assign wd_expire = (st_r.wd_cnt == DFM_WDW'(1));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < DFM_NFLAG; i++) begin
      if (DFM_STARTUP_MASK[i] && !startup_active) begin
        st_nxt.flags[i] = st_r.flags[i];
      end else if (DFM_STATIC_MASK[i]) begin
        st_nxt.flags[i] = st_r.flags[i] | cause[i];
      end else if (DFM_STARTUP_MASK[i]) begin
        // Start-up temporary flags track each checked word
        st_nxt.flags[i] = nvm_in.valid ? cause[i] : st_r.flags[i];
      end else begin
        st_nxt.flags[i] = cause[i];
      end
    end
    // Set wins over the host clear
    if (wd_flag_clr && !wd_expire) begin
      st_nxt.flags[F_WDOG] = 1'b0;
    end

    if (wd_load) begin
      st_nxt.wd_cnt = wd_value;
      st_nxt.wd_reload = wd_value;
    end else if (wd_expire) begin
      st_nxt.wd_cnt = st_r.wd_reload;
    end else if (st_r.wd_cnt != '0) begin
      st_nxt.wd_cnt = st_r.wd_cnt - DFM_WDW'(1);
    end

    if (fault_in.obuf_check && !st_r.obuf_latched) begin
      if (fault_in.obuf_fault) begin
        if (st_r.obuf_cnt == DFM_CHKW'(DFM_OBUF_TRIES - 1)) begin
          st_nxt.obuf_latched = 1'b1;
          st_nxt.obuf_cnt = DFM_CHK_RST;
        end else begin
          st_nxt.obuf_cnt = st_r.obuf_cnt + DFM_CHKW'(1);
        end
      end else begin
        st_nxt.obuf_cnt = DFM_CHK_RST;
      end
    end
    if (obuf_static_clr && !st_nxt.obuf_latched) begin
      st_nxt.flags[F_OBUF_STAT] = 1'b0;
    end else if (obuf_static_clr && st_r.obuf_latched) begin
      st_nxt.obuf_latched = 1'b0;
      st_nxt.flags[F_OBUF_STAT] = 1'b0;
      st_nxt.obuf_cnt = DFM_CHK_RST;
    end else begin
      st_nxt.flags[F_OBUF_STAT] = st_r.flags[F_OBUF_STAT] | st_nxt.obuf_latched;
    end

    if (nvm_in.valid && startup_active) begin
      st_nxt.nvm_data = nvm_in.sed ? (nvm_in.data ^ nvm_in.syndrome_fix) : nvm_in.data;
    end
    st_nxt.shd_data = fault_in.shd_sed ? (shd_raw ^ shd_fix) : shd_raw;

    st_nxt.alarm_n = ~|(st_nxt.flags & irq_enable);

    if (st_nxt.obuf_latched || st_nxt.flags[F_OBUF_TMP]) begin
      st_nxt.out_mode = DFM_OUT_OFF;
    end else if (|(st_nxt.flags & diag_enable)) begin
      st_nxt.out_mode = DFM_OUT_DIAG;
    end else begin
      st_nxt.out_mode = DFM_OUT_NORMAL;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '{flags: DFM_FLAGS_RST, wd_cnt: '0, wd_reload: '0, obuf_cnt: DFM_CHK_RST, obuf_latched: 1'b0,
                nvm_data: '0, shd_data: '0, alarm_n: 1'b1, out_mode: DFM_OUT_NORMAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;
  assign alarm_request_n = st_r.alarm_n;
  assign out_mode = st_r.out_mode;
  assign nvm_data_out = st_r.nvm_data;
  assign shd_data_out = st_r.shd_data;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_temp_follow;
    @(posedge clk_sys) disable iff (rst) 1'b1 ##1 (flags[F_OVERV] == $past(fault_in.ext_over));
  endproperty
  a_temp_follow: assert property (p_temp_follow) else $error("over-voltage flag wrong");

  property p_under;
    @(posedge clk_sys) disable iff (rst) fault_in.ext_under |=> flags[F_UNDERV];
  endproperty
  a_under: assert property (p_under) else $error("under-voltage flag missing");

  property p_static_hold;
    @(posedge clk_sys) disable iff (rst) flags[F_CRACK] |=> flags[F_CRACK] [*8];
  endproperty
  a_static_hold: assert property (p_static_hold) else $error("static flag dropped");

  property p_alarm;
    @(posedge clk_sys) disable iff (rst) (|(flags & $past(irq_enable))) == !alarm_request_n;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm level wrong");

  property p_mask;
    @(posedge clk_sys) disable iff (rst) (irq_enable == '0) |=> alarm_request_n;
  endproperty
  a_mask: assert property (p_mask) else $error("alarm without enable");

  property p_offset_off;
    @(posedge clk_sys) disable iff (rst) flags[F_OBUF_TMP] |-> out_mode == DFM_OUT_OFF;
  endproperty
  a_offset_off: assert property (p_offset_off) else $error("outputs not off");

  property p_shd_fix;
    @(posedge clk_sys) disable iff (rst) fault_in.shd_sed |=> shd_data_out == $past(shd_raw ^ shd_fix);
  endproperty
  a_shd_fix: assert property (p_shd_fix) else $error("shadow not corrected");

  property p_wd_stop;
    @(posedge clk_sys) disable iff (rst) (wd_load && wd_value == '0) ##1 !wd_load [*4] |-> !wd_expire;
  endproperty
  a_wd_stop: assert property (p_wd_stop) else $error("watchdog not halted");

  property p_wd_flag;
    @(posedge clk_sys) disable iff (rst) wd_expire |=> flags[F_WDOG];
  endproperty
  a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag missing");

  property p_wd_clr;
    @(posedge clk_sys) disable iff (rst) (wd_flag_clr && !wd_expire) |=> !flags[F_WDOG];
  endproperty
  a_wd_clr: assert property (p_wd_clr) else $error("watchdog flag not cleared");

  property p_ana_uv;
    @(posedge clk_sys) disable iff (rst) fault_in.ana_uv |=> flags[F_ANA_UV];
  endproperty
  a_ana_uv: assert property (p_ana_uv) else $error("analog rail flag missing");

  property p_proto;
    @(posedge clk_sys) disable iff (rst) fault_in.proto_err |=> flags[F_PROTO];
  endproperty
  a_proto: assert property (p_proto) else $error("protocol flag missing");

  property p_shd_ded;
    @(posedge clk_sys) disable iff (rst) fault_in.shd_ded |=> flags[F_SHD_DED];
  endproperty
  a_shd_ded: assert property (p_shd_ded) else $error("shadow double error flag missing");

  property p_shd_sed;
    @(posedge clk_sys) disable iff (rst) fault_in.shd_sed |=> flags[F_SHD_SED];
  endproperty
  a_shd_sed: assert property (p_shd_sed) else $error("shadow single error flag missing");

  property p_nvm_frozen;
    @(posedge clk_sys) disable iff (rst) !startup_active |=> $stable(flags[F_NVM_SED:F_NVM_DED]);
  endproperty
  a_nvm_frozen: assert property (p_nvm_frozen) else $error("memory flags moved after start-up");

  property p_nvm_ded;
    @(posedge clk_sys) disable iff (rst) (startup_active && nvm_in.valid && nvm_in.ded) |=> flags[F_NVM_DED];
  endproperty
  a_nvm_ded: assert property (p_nvm_ded) else $error("memory double error flag missing");

  property p_nvm_fix;
    @(posedge clk_sys) disable iff (rst) (startup_active && nvm_in.valid && nvm_in.sed) |=>
      nvm_data_out == $past(nvm_in.data ^ nvm_in.syndrome_fix);
  endproperty
  a_nvm_fix: assert property (p_nvm_fix) else $error("memory word not corrected");

  property p_txo_freq;
    @(posedge clk_sys) disable iff (rst) (txo_freq < txo_freq_lo || txo_freq > txo_freq_hi) |=> flags[F_TXO_FREQ];
  endproperty
  a_txo_freq: assert property (p_txo_freq) else $error("frequency flag missing");

  property p_txo_stop;
    @(posedge clk_sys) disable iff (rst) !txo_running |=> flags[F_TXO_STOP];
  endproperty
  a_txo_stop: assert property (p_txo_stop) else $error("oscillator stop flag missing");

  property p_int_osc;
    @(posedge clk_sys) disable iff (rst) (fault_in.int_osc_fail || flags[F_INT_OSC]) |=> flags[F_INT_OSC];
  endproperty
  a_int_osc: assert property (p_int_osc) else $error("internal oscillator flag lost");

  property p_crack_set;
    @(posedge clk_sys) disable iff (rst) fault_in.crack |=> flags[F_CRACK];
  endproperty
  a_crack_set: assert property (p_crack_set) else $error("crack flag missing");

  property p_obuf_tmp;
    @(posedge clk_sys) disable iff (rst) fault_in.obuf_fault |=> flags[F_OBUF_TMP];
  endproperty
  a_obuf_tmp: assert property (p_obuf_tmp) else $error("offset flag missing");

  property p_obuf_fall;
    @(posedge clk_sys) disable iff (rst) !fault_in.obuf_fault |=> !flags[F_OBUF_TMP];
  endproperty
  a_obuf_fall: assert property (p_obuf_fall) else $error("offset flag stuck");

  property p_obuf_latch;
    @(posedge clk_sys) disable iff (rst) (flags[F_OBUF_STAT] && !obuf_static_clr) |=>
      (flags[F_OBUF_STAT] && out_mode == DFM_OUT_OFF);
  endproperty
  a_obuf_latch: assert property (p_obuf_latch) else $error("buffer latch released");

  property p_obuf_clr;
    @(posedge clk_sys) disable iff (rst) (obuf_static_clr && flags[F_OBUF_STAT]) |=> !flags[F_OBUF_STAT];
  endproperty
  a_obuf_clr: assert property (p_obuf_clr) else $error("buffer latch not cleared");

  property p_diag;
    @(posedge clk_sys) disable iff (rst) ((|(flags & $past(diag_enable))) && !flags[F_OBUF_TMP] &&
      !flags[F_OBUF_STAT]) |-> out_mode == DFM_OUT_DIAG;
  endproperty
  a_diag: assert property (p_diag) else $error("outputs not in diagnostic state");

  c_alarm: cover property (@(posedge clk_sys) disable iff (rst) $fell(alarm_request_n));
  c_diag: cover property (@(posedge clk_sys) disable iff (rst) out_mode == DFM_OUT_DIAG);
  c_latch: cover property (@(posedge clk_sys) disable iff (rst) $rose(st_r.obuf_latched));
  c_wd: cover property (@(posedge clk_sys) disable iff (rst) wd_expire ##[1:100] wd_expire);

endmodule : dfm_monitor

// [rtl/dfm_pkg.sv]
package dfm_pkg;

  // ---------------------------------------------------------------
  // Flag positions
  // ---------------------------------------------------------------
  localparam int DFM_NFLAG = 20;
  localparam int F_OVERV = 0;
  localparam int F_UNDERV = 1;
  localparam int F_ANA_UV = 2;
  localparam int F_DATA_ACC = 3;
  localparam int F_PROTO = 4;
  localparam int F_SHD_DED = 5;
  localparam int F_SHD_SED = 6;
  localparam int F_NVM_DED = 7;
  localparam int F_NVM_SED = 8;
  localparam int F_TXO_FREQ = 9;
  localparam int F_TXO_STOP = 10;
  localparam int F_INT_OSC = 11;
  localparam int F_BUS = 12;
  localparam int F_WDOG = 13;
  localparam int F_CRACK = 14;
  localparam int F_OBUF_TMP = 15;
  localparam int F_OBUF_STAT = 16;
  localparam int F_RSV0 = 17;
  localparam int F_RSV1 = 18;
  localparam int F_RSV2 = 19;

  // Static flags: held until reset (buffer static and watchdog also host clearable)
  localparam logic [DFM_NFLAG-1:0] DFM_STATIC_MASK = 20'h168a0;
  // Start-up only flags
  localparam logic [DFM_NFLAG-1:0] DFM_STARTUP_MASK = 20'h00180;
  localparam logic [DFM_NFLAG-1:0] DFM_FLAGS_RST = 20'h00000;

  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int DFM_DW = 16;
  localparam int DFM_FW = 16;
  localparam int DFM_WDW = 16;
  localparam int DFM_OBUF_TRIES = 8;
  localparam int DFM_CHKW = 4;
  localparam logic [DFM_CHKW-1:0] DFM_CHK_RST = 4'h0;

  typedef enum logic [1:0] {
    DFM_OUT_NORMAL,
    DFM_OUT_DIAG,
    DFM_OUT_OFF
  } dfm_out_mode_t;

  // Fault inputs from analog/digital detectors
  typedef struct packed {
    logic ext_over;
    logic ext_under;
    logic ana_uv;
    logic data_acc;
    logic proto_err;
    logic shd_ded;
    logic shd_sed;
    logic int_osc_fail;
    logic bus_fail;
    logic crack;
    logic obuf_fault;
    logic obuf_check;
  } dfm_fault_t;

  // Nonvolatile memory word check during start-up
  typedef struct packed {
    logic valid;
    logic ded;
    logic sed;
    logic [DFM_DW-1:0] data;
    logic [DFM_DW-1:0] syndrome_fix;
  } dfm_nvm_t;

  typedef struct packed {
    logic [DFM_NFLAG-1:0] flags;
    logic [DFM_WDW-1:0] wd_cnt;
    logic [DFM_WDW-1:0] wd_reload;
    logic [DFM_CHKW-1:0] obuf_cnt;
    logic obuf_latched;
    logic [DFM_DW-1:0] nvm_data;
    logic [DFM_DW-1:0] shd_data;
    logic alarm_n;
    dfm_out_mode_t out_mode;
  } dfm_state_t;

endpackage : dfm_pkg

// [verif/dfm_host_model.sv]
`timescale 1ns/10ps

// -------------------------------------------
// Host side: watchdog load and flag clears
// -------------------------------------------
module dfm_host_model
  import dfm_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Control towards the monitor
  output logic wd_load,
  output logic [dfm_pkg::DFM_WDW-1:0] wd_value,
  output logic obuf_static_clr,
  output logic wd_flag_clr
);
  initial begin
    wd_load = 1'b0;
    wd_value = 16'h0000;
    obuf_static_clr = 1'b0;
    wd_flag_clr = 1'b0;
  end

  task load_wd(input logic [DFM_WDW-1:0] v);
    wd_value = v;
    wd_load = 1'b1;
    @(negedge clk_sys);
    wd_load = 1'b0;
  endtask : load_wd

  task clr_wd();
    wd_flag_clr = 1'b1;
    @(negedge clk_sys);
    wd_flag_clr = 1'b0;
  endtask : clr_wd

  task clr_obuf();
    obuf_static_clr = 1'b1;
    @(negedge clk_sys);
    obuf_static_clr = 1'b0;
  endtask : clr_obuf
endmodule : dfm_host_model

// [verif/tb.sv]
`timescale 1ns/10ps

module tb;
  import dfm_pkg::*;
  logic clk_sys, rst, startup_active, txo_running, wd_load, obuf_static_clr, wd_flag_clr, alarm_request_n;
  dfm_fault_t fault_in;
  dfm_nvm_t nvm_in;
  logic [DFM_DW-1:0] shd_raw, shd_fix, nvm_data_out, shd_data_out, txo_freq, wd_value;
  logic [DFM_NFLAG-1:0] irq_enable, diag_enable, flags;
  dfm_out_mode_t out_mode;
  int err_total = 0;
  int samples_checked = 0;
  int fmap [10] = '{F_OVERV, F_UNDERV, F_ANA_UV, F_DATA_ACC, F_PROTO, F_SHD_DED, F_SHD_SED, F_INT_OSC, F_BUS, F_CRACK};
  logic [9:0] stc = 10'h2a0;
  logic [DFM_FW-1:0] freq_lo = 16'h000a;
  logic [DFM_FW-1:0] freq_hi = 16'h0014;
  int fq [5] = '{15, 20, 21, 10, 9};
  logic [4:0] fx = 5'h14;

  dfm_monitor dfm_monitor_i (.clk_sys(clk_sys), .rst(rst), .fault_in(fault_in), .startup_active(startup_active),
    .nvm_in(nvm_in), .shd_raw(shd_raw), .shd_fix(shd_fix), .txo_freq(txo_freq), .txo_running(txo_running),
    .txo_freq_lo(freq_lo), .txo_freq_hi(freq_hi), .irq_enable(irq_enable), .diag_enable(diag_enable),
    .wd_load(wd_load), .wd_value(wd_value), .obuf_static_clr(obuf_static_clr), .wd_flag_clr(wd_flag_clr),
    .flags(flags), .alarm_request_n(alarm_request_n), .out_mode(out_mode), .nvm_data_out(nvm_data_out),
    .shd_data_out(shd_data_out));
  dfm_host_model dfm_host_model_i (.clk_sys(clk_sys), .wd_load(wd_load), .wd_value(wd_value),
    .obuf_static_clr(obuf_static_clr), .wd_flag_clr(wd_flag_clr));

  // -------------------------------------------
  // Helpers
  // -------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task give_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task do_reset();
    rst = 1'b1;
    tick(5);
    rst = 1'b0;
    chk(flags, 0);
    chk({alarm_request_n, out_mode}, {1'b1, DFM_OUT_NORMAL});
  endtask : do_reset

  task wait_flag(input int b, output int n);
    n = 0;
    while (flags[b] !== 1'b1) begin
      tick(1);
      n++;
      if (n > 20) begin
        chk(0, 1);
        give_verdict();
      end
    end
  endtask : wait_flag

  // -------------------------------------------
  // Scenarios
  // -------------------------------------------
  task t_faults();
    for (int i = 0; i < 10; i++) begin
      do_reset();
      irq_enable = '0;
      fault_in = dfm_fault_t'(12'h800 >> i);
      tick(1);
      chk(flags, 20'h1 << fmap[i]);
      chk(alarm_request_n, 1);
      irq_enable = 20'h1 << fmap[i];
      diag_enable = irq_enable;
      tick(1);
      chk(alarm_request_n, 0);
      chk(out_mode, DFM_OUT_DIAG);
      fault_in = '0;
      tick(1);
      chk(flags[fmap[i]], stc[i]);
      chk(alarm_request_n, !stc[i]);
    end
    diag_enable = '0;
  endtask : t_faults

  task t_nvm();
    do_reset();
    startup_active = 1'b1;
    nvm_in = '{1'b1, 1'b0, 1'b1, 16'h1234, 16'h0010};
    tick(1);
    chk(flags[F_NVM_SED], 1);
    chk(nvm_data_out, 16'h1224);
    nvm_in = '{1'b1, 1'b1, 1'b0, 16'h0000, 16'h0000};
    tick(1);
    nvm_in = '0;
    startup_active = 1'b0;
    tick(2);
    chk(flags[F_NVM_DED], 1);
    chk(flags[F_NVM_SED], 0);
    do_reset();
    nvm_in = '{1'b1, 1'b1, 1'b1, 16'h0000, 16'h0001};
    tick(2);
    chk(flags[F_NVM_SED:F_NVM_DED], 0);
    chk(nvm_data_out, 0);
    nvm_in = '0;
    shd_raw = 16'h00f0;
    shd_fix = 16'h0011;
    fault_in.shd_sed = 1'b1;
    tick(1);
    chk(shd_data_out, 16'h00e1);
    chk(flags[F_SHD_SED], 1);
    fault_in.shd_sed = 1'b0;
    tick(1);
    chk(shd_data_out, 16'h00f0);
    chk(flags[F_SHD_SED], 0);
  endtask : t_nvm

  task t_txo();
    for (int i = 0; i < 5; i++) begin
      txo_freq = fq[i];
      tick(1);
      chk(flags[F_TXO_FREQ], fx[i]);
    end
    freq_hi = 16'h0030;
    txo_freq = 16'h0015;
    tick(1);
    chk(flags[F_TXO_FREQ], 0);
    txo_freq = 16'h000f;
    txo_running = 1'b0;
    tick(1);
    chk(flags[F_TXO_STOP], 1);
    txo_running = 1'b1;
    tick(1);
    chk(flags[F_TXO_STOP], 0);
  endtask : t_txo

  task t_wdog();
    int n;
    do_reset();
    dfm_host_model_i.load_wd(16'h0004);
    wait_flag(F_WDOG, n);
    dfm_host_model_i.clr_wd();
    chk(flags[F_WDOG], 0);
    wait_flag(F_WDOG, n);
    chk(n + 1, 4);
    dfm_host_model_i.clr_wd();
    dfm_host_model_i.load_wd(16'h0001);
    dfm_host_model_i.clr_wd();
    chk(flags[F_WDOG], 1);
    dfm_host_model_i.load_wd(16'h0000);
    dfm_host_model_i.clr_wd();
    tick(12);
    chk(flags[F_WDOG], 0);
  endtask : t_wdog

  task checks(input int n);
    repeat (n) begin
      fault_in.obuf_check = 1'b1;
      tick(1);
      fault_in.obuf_check = 1'b0;
      tick(1);
    end
  endtask : checks

  task t_obuf();
    do_reset();
    diag_enable = '1;
    fault_in.obuf_fault = 1'b1;
    tick(1);
    chk(flags[F_OBUF_TMP], 1);
    chk(out_mode, DFM_OUT_OFF);
    checks(7);
    fault_in.obuf_fault = 1'b0;
    checks(1);
    fault_in.obuf_fault = 1'b1;
    checks(7);
    chk(flags[F_OBUF_STAT], 0);
    checks(1);
    chk(flags[F_OBUF_STAT], 1);
    fault_in.obuf_fault = 1'b0;
    tick(2);
    chk({flags[F_OBUF_TMP], out_mode}, {1'b0, DFM_OUT_OFF});
    dfm_host_model_i.clr_obuf();
    tick(1);
    chk({flags[F_OBUF_STAT], out_mode}, {1'b0, DFM_OUT_NORMAL});
  endtask : t_obuf

  // -------------------------------------------
  // Main sequence
  // -------------------------------------------
  initial begin
    rst = 1'b1;
    fault_in = '0;
    startup_active = 1'b0;
    nvm_in = '0;
    shd_raw = '0;
    shd_fix = '0;
    txo_freq = 16'h000f;
    txo_running = 1'b1;
    irq_enable = '0;
    diag_enable = '0;
    tick(1);
    t_faults();
    t_nvm();
    t_txo();
    t_wdog();
    t_obuf();
    give_verdict();
  end
endmodule : tb
